/* File: bmdi_ctrl.sv */
`timescale 1ns/1ps
module bmdi_ctrl
   import bmdi_pkg::*;
#(
   parameter int unsigned DISC_HOLD_CYCLES   = DISC_HOLD_CYC,
   parameter int unsigned SHUT_SOFT_CYCLES   = SHUT_SOFT_CYC,
   parameter int unsigned SHUT_HARD_CYCLES   = SHUT_HARD_CYC,
   parameter int unsigned RESTORE_ACK_CYCLES = RESTORE_ACK_CYC
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic disconnect_in,
   input  wire logic uvlo_switch_in,
   input  wire logic net_reset_switch_in,
   input  wire logic factory_restore_switch_in,
   input  wire logic shutdown_in,
   input  wire logic enable_in,
   input  wire logic disconnect_handling_select,
   input  wire logic disconnect_polarity,
   input  wire logic fw_contactor_request,
   input  wire logic fw_stack_release_done,
   input  wire logic fw_restore_done,
   input  wire logic uvlo_event,
   output logic      contactor_drive_en,
   output logic      stack_release_request,
   output logic      shutdown_release_request,
   output logic      power_hold,
   output logic      disconnect_state,
   output logic      uvlo_enable_state,
   output logic      net_reset_state,
   output logic      factory_restore_state,
   output logic      shutdown_state,
   output logic      enable_state,
   output logic      restore_indicate,
   output logic      restore_factory_sel,
   output logic      net_reset_start,
   output logic      factory_restore_start,
   output logic      reboot_request
);
   bmdi_sync_if #(.N(IN_COUNT)) sync_bus ();

   logic        disc_lvl;
   logic        uvlo_lvl;
   logic        netrst_lvl;
   logic        fact_lvl;
   logic        shut_lvl;
   logic        en_lvl;
   logic        disc_act;
   logic        fast_cut;
   logic        off_allow;
   logic [31:0] disc_cnt_reg;
   logic [31:0] shut_cnt_reg;
   logic [31:0] boot_cnt_reg;
   logic [1:0]  settle_reg;
   bmdi_pwr_t   pwr_reg;
   bmdi_rst_t   rs_reg;
   logic        contactor_reg;
   logic        stack_req_reg;
   logic        shut_req_reg;
   logic        fact_sel_reg;
   logic        net_start_reg;
   logic        fact_start_reg;
   logic        reboot_reg;
   logic        disc_stat_reg;
   logic        uvlo_stat_reg;
   logic        netrst_stat_reg;
   logic        fact_stat_reg;
   logic        shut_stat_reg;
   logic        en_stat_reg;

   assign sync_bus.raw[IN_DISC]   = disconnect_in;
   assign sync_bus.raw[IN_UVLO]   = uvlo_switch_in;
   assign sync_bus.raw[IN_NETRST] = net_reset_switch_in;
   assign sync_bus.raw[IN_FACT]   = factory_restore_switch_in;
   assign sync_bus.raw[IN_SHUT]   = shutdown_in;
   assign sync_bus.raw[IN_EN]     = enable_in;

   bmdi_sync #(.N(IN_COUNT)) u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .sif   (sync_bus.sync_side)
   );

   assign disc_lvl   = sync_bus.level[IN_DISC];
   assign uvlo_lvl   = sync_bus.level[IN_UVLO];
   assign netrst_lvl = sync_bus.level[IN_NETRST];
   assign fact_lvl   = sync_bus.level[IN_FACT];
   assign shut_lvl   = sync_bus.level[IN_SHUT];
   assign en_lvl     = sync_bus.level[IN_EN];

   // Sync flops reset low, which reads as active for polarity 0
   assign disc_act  = ~(disc_lvl ^ disconnect_polarity)
                      && (rs_reg != RS_SETTLE);
   assign fast_cut  = (disconnect_handling_select == MODE_FAST)
                      && disc_act;
   // Lockout switch OFF or enable held keeps the rail up
   assign off_allow = uvlo_lvl && !en_lvl;

   // Disconnect assertion time, saturating
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         disc_cnt_reg <= CNT_RESET;
      else if (!disc_act)
         disc_cnt_reg <= CNT_RESET;
      else if (disc_cnt_reg < DISC_HOLD_CYCLES)
         disc_cnt_reg <= disc_cnt_reg + 32'h1;
   end

   // Software path only reacts to a fully held request
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         stack_req_reg <= BIT_RESET;
      else
         stack_req_reg <= (disconnect_handling_select == MODE_SOFT)
                          && disc_act
                          && (disc_cnt_reg == DISC_HOLD_CYCLES - 1);
   end

   // Fast mode cuts every contactor in one edge; this costs contact wear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         contactor_reg <= BIT_RESET;
      else
         contactor_reg <= fw_contactor_request && !fast_cut
                          && (pwr_reg != PWR_OFF);
   end

   // Shutdown assertion time, cleared on any gap
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         shut_cnt_reg <= CNT_RESET;
      else if (!shut_lvl)
         shut_cnt_reg <= CNT_RESET;
      else if (shut_cnt_reg < SHUT_HARD_CYCLES)
         shut_cnt_reg <= shut_cnt_reg + 32'h1;
   end

   // Power rail state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pwr_reg      <= PWR_ON;
         shut_req_reg <= BIT_RESET;
      end
      else
      begin
         shut_req_reg <= BIT_RESET;
         case (pwr_reg)
            PWR_ON:
            begin
               if (off_allow && uvlo_event)
                  pwr_reg <= PWR_OFF;
               else if (off_allow && shut_cnt_reg >= SHUT_HARD_CYCLES - 1)
                  pwr_reg <= PWR_OFF;
               else if (off_allow && shut_cnt_reg >= SHUT_SOFT_CYCLES - 1)
               begin
                  pwr_reg      <= PWR_SEQ;
                  shut_req_reg <= 1'b1;
               end
            end
            PWR_SEQ:
            begin
               // Enable or a disabled lockout switch aborts the power-off
               if (!off_allow)
                  pwr_reg <= PWR_ON;
               else if (fw_stack_release_done || uvlo_event)
                  pwr_reg <= PWR_OFF;
               else if (shut_cnt_reg >= SHUT_HARD_CYCLES - 1)
                  pwr_reg <= PWR_OFF;
            end
            PWR_OFF:
            begin
               if (en_lvl)
                  pwr_reg <= PWR_ON;
            end
            default:
               pwr_reg <= PWR_ON;
         endcase
      end
   end

   // Time since boot, for the restore acknowledge window
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         boot_cnt_reg <= CNT_RESET;
      else if (boot_cnt_reg < RESTORE_ACK_CYCLES)
         boot_cnt_reg <= boot_cnt_reg + 32'h1;
   end

   // Restore request handling; switches are sampled once after boot
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rs_reg         <= RS_SETTLE;
         settle_reg     <= 2'h0;
         fact_sel_reg   <= BIT_RESET;
         net_start_reg  <= BIT_RESET;
         fact_start_reg <= BIT_RESET;
         reboot_reg     <= BIT_RESET;
      end
      else
      begin
         net_start_reg  <= BIT_RESET;
         fact_start_reg <= BIT_RESET;
         reboot_reg     <= BIT_RESET;
         case (rs_reg)
            RS_SETTLE:
            begin
               settle_reg <= settle_reg + 2'h1;
               // Switches were set while unpowered
               if (settle_reg == SETTLE_CYC)
               begin
                  if (fact_lvl)
                  begin
                     rs_reg       <= RS_WAIT;
                     fact_sel_reg <= 1'b1;
                  end
                  else if (netrst_lvl)
                  begin
                     rs_reg       <= RS_WAIT;
                     fact_sel_reg <= 1'b0;
                  end
                  else
                     rs_reg <= RS_IDLE;
               end
            end
            RS_WAIT:
            begin
               // Acknowledge wins over timeout in the same cycle
               if (!fact_lvl && !netrst_lvl)
               begin
                  rs_reg         <= RS_RUN;
                  fact_start_reg <= fact_sel_reg;
                  net_start_reg  <= !fact_sel_reg;
               end
               else if (boot_cnt_reg >= RESTORE_ACK_CYCLES - 1)
                  rs_reg <= RS_IDLE;
            end
            RS_RUN:
            begin
               if (fw_restore_done)
               begin
                  rs_reg     <= RS_IDLE;
                  reboot_reg <= fact_sel_reg;
               end
            end
            RS_IDLE:
               rs_reg <= RS_IDLE;
            default:
               rs_reg <= RS_IDLE;
         endcase
      end
   end

   // Status bits
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         disc_stat_reg   <= BIT_RESET;
         uvlo_stat_reg   <= BIT_RESET;
         netrst_stat_reg <= BIT_RESET;
         fact_stat_reg   <= BIT_RESET;
         shut_stat_reg   <= BIT_RESET;
         en_stat_reg     <= BIT_RESET;
      end
      else
      begin
         disc_stat_reg   <= disc_lvl;
         uvlo_stat_reg   <= uvlo_lvl;
         netrst_stat_reg <= netrst_lvl;
         fact_stat_reg   <= fact_lvl;
         shut_stat_reg   <= shut_lvl && (pwr_reg != PWR_OFF);
         en_stat_reg     <= en_lvl;
      end
   end

   assign contactor_drive_en       = contactor_reg;
   assign stack_release_request    = stack_req_reg;
   assign shutdown_release_request = shut_req_reg;
   assign power_hold               = (pwr_reg != PWR_OFF);
   assign disconnect_state         = disc_stat_reg;
   assign uvlo_enable_state        = uvlo_stat_reg;
   assign net_reset_state          = netrst_stat_reg;
   assign factory_restore_state    = fact_stat_reg;
   assign shutdown_state           = shut_stat_reg;
   assign enable_state             = en_stat_reg;
   assign restore_indicate         = (rs_reg == RS_WAIT)
                                     || (rs_reg == RS_RUN);
   assign restore_factory_sel      = fact_sel_reg;
   assign net_reset_start          = net_start_reg;
   assign factory_restore_start    = fact_start_reg;
   assign reboot_request           = reboot_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_fast_active;
      (disconnect_handling_select == MODE_FAST) && disc_act;
   endsequence

   sequence s_soft_held;
      (disconnect_handling_select == MODE_SOFT) && disc_act
      && (disc_cnt_reg == DISC_HOLD_CYCLES - 1);
   endsequence

   sequence s_hard_hit;
      off_allow && (pwr_reg != PWR_OFF)
      && (shut_cnt_reg >= SHUT_HARD_CYCLES - 1);
   endsequence

   sequence s_wait_expired;
      (rs_reg == RS_WAIT) && (fact_lvl || netrst_lvl)
      && (boot_cnt_reg >= RESTORE_ACK_CYCLES - 1);
   endsequence

   a_fast_release: assert property (
      s_fast_active |=> !contactor_drive_en)
      else $error("contactors still driven in fast disconnect");

   a_soft_keeps_drive: assert property (
      (disconnect_handling_select == MODE_SOFT) && fw_contactor_request
      && (pwr_reg != PWR_OFF) |=> contactor_drive_en)
      else $error("sequenced mode released contactors directly");

   a_soft_request: assert property (
      s_soft_held |=> stack_release_request ##1 !stack_release_request)
      else $error("sequenced disconnect request not a single pulse");

   a_disc_status: assert property (
      $past(rst_n, 1) && $past(rst_n, 2) && $past(rst_n, 3)
      |-> disconnect_state == $past(disconnect_in, 3))
      else $error("disconnect status does not follow the pin");

   a_soft_shutdown: assert property (
      (pwr_reg == PWR_ON) && off_allow && !uvlo_event
      && (shut_cnt_reg == SHUT_SOFT_CYCLES - 1)
      |=> shutdown_release_request && (pwr_reg == PWR_SEQ))
      else $error("shutdown sequence not started at threshold");

   a_hard_power_off: assert property (
      s_hard_hit |=> !power_hold)
      else $error("long shutdown did not remove power");

   a_off_allowed: assert property (
      $fell(power_hold) |-> $past(uvlo_lvl) && !$past(en_lvl))
      else $error("power removed while lockout off or enable held");

   a_enable_wake: assert property (
      (pwr_reg == PWR_OFF) && en_lvl |=> power_hold)
      else $error("enable did not restore power");

   a_restore_ack: assert property (
      (rs_reg == RS_WAIT) && !fact_lvl && !netrst_lvl
      |=> (net_reset_start ^ factory_restore_start) && restore_indicate)
      else $error("acknowledge did not start the restore");

   a_restore_abort: assert property (
      s_wait_expired |=> !restore_indicate && !net_reset_start
      && !factory_restore_start)
      else $error("restore not abandoned after timeout");

   a_reboot_cause: assert property (
      reboot_request |-> $past(restore_factory_sel) && $past(fw_restore_done))
      else $error("reboot without a finished factory restore");
endmodule

/* File: bmdi_ext_ctrl.sv */
`timescale 1ns/1ps
module bmdi_ext_ctrl
   import bmdi_pkg::*;
#(
   parameter int unsigned HOLD = DISC_HOLD_CYC
)
(
   input  wire logic clk,
   input  wire logic polarity,
   output logic      disconnect_in,
   output logic      uvlo_switch_in,
   output logic      net_reset_switch_in,
   output logic      factory_restore_switch_in,
   output logic      shutdown_in,
   output logic      enable_in
);
   logic        disc_act;
   int unsigned held = 0;

   // Idle level is the inverse of the active one
   assign disconnect_in = disc_act ? polarity : ~polarity;

   always @(posedge clk)
      held <= disc_act ? held + 1 : 0;

   initial
   begin
      disc_act = 1'b0;
      uvlo_switch_in = 1'b1;
      net_reset_switch_in = 1'b0;
      factory_restore_switch_in = 1'b0;
      shutdown_in = 1'b0;
      enable_in = 1'b0;
   end

   // Early release only when a glitch is asked for on purpose
   task automatic set_disc(input logic act, input logic early);
      while (!act && !early && held < HOLD)
      begin
         @(posedge clk);
         #1;
      end
      disc_act = act;
   endtask

   // Only called while the device is held in reset
   task automatic boot_sel(input logic net, input logic fact);
      net_reset_switch_in = net;
      factory_restore_switch_in = fact;
   endtask

   // Both switches back off acknowledge the restore
   task automatic ack_restore();
      net_reset_switch_in = 1'b0;
      factory_restore_switch_in = 1'b0;
   endtask

   task automatic drive(input logic sd, input logic en, input logic uv);
      shutdown_in = sd;
      enable_in = en;
      uvlo_switch_in = uv;
   endtask
endmodule

/* File: bmdi_pkg.sv */
package bmdi_pkg;

   // System clock and derived cycle counts
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned DISC_HOLD_MS   = 500;
   localparam int unsigned SHUT_SOFT_MS   = 500;
   localparam int unsigned SHUT_HARD_MS   = 10_000;
   localparam int unsigned RESTORE_ACK_MS = 30_000;
   localparam int unsigned DISC_HOLD_CYC  = DISC_HOLD_MS * CYC_PER_MS;
   localparam int unsigned SHUT_SOFT_CYC  = SHUT_SOFT_MS * CYC_PER_MS;
   localparam int unsigned SHUT_HARD_CYC  = SHUT_HARD_MS * CYC_PER_MS;
   localparam int unsigned RESTORE_ACK_CYC = RESTORE_ACK_MS * CYC_PER_MS;

   // Synchroniser settle time before boot switches are decoded
   localparam logic [1:0]  SETTLE_CYC     = 2'h3;

   // Positions of the discrete inputs on the synchroniser bus
   localparam int unsigned IN_COUNT       = 6;
   localparam int unsigned IN_DISC        = 0;
   localparam int unsigned IN_UVLO        = 1;
   localparam int unsigned IN_NETRST      = 2;
   localparam int unsigned IN_FACT        = 3;
   localparam int unsigned IN_SHUT        = 4;
   localparam int unsigned IN_EN          = 5;

   // Configuration encodings and reset values
   localparam logic        MODE_SOFT      = 1'b0;
   localparam logic        MODE_FAST      = 1'b1;
   localparam logic        BIT_RESET      = 1'b0;
   localparam logic [31:0] CNT_RESET      = 32'h0;

   typedef enum logic [2:0]
   {
      PWR_ON  = 3'h1,
      PWR_SEQ = 3'h2,
      PWR_OFF = 3'h4
   } bmdi_pwr_t;

   typedef enum logic [3:0]
   {
      RS_SETTLE = 4'h1,
      RS_WAIT   = 4'h2,
      RS_RUN    = 4'h4,
      RS_IDLE   = 4'h8
   } bmdi_rst_t;

endpackage

/* File: bmdi_sync.sv */
`timescale 1ns/1ps
module bmdi_sync
   import bmdi_pkg::*;
#(
   parameter int unsigned N = IN_COUNT
)
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   bmdi_sync_if.sync_side sif
);
   logic [N-1:0] meta_reg;
   logic [N-1:0] level_reg;

   // Two flops per pin; only the second stage is used downstream
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               meta_reg[i]  <= BIT_RESET;
               level_reg[i] <= BIT_RESET;
            end
            else
            begin
               meta_reg[i]  <= sif.raw[i];
               level_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign sif.level = level_reg;
endmodule

/* File: bmdi_sync_if.sv */
`timescale 1ns/1ps
interface bmdi_sync_if
   import bmdi_pkg::*;
#(
   parameter int unsigned N = IN_COUNT
)
();
   logic [N-1:0] raw;
   logic [N-1:0] level;

   modport sync_side
   (
      input  raw,
      output level
   );

   modport user
   (
      output raw,
      input  level
   );
endinterface

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import bmdi_pkg::*;

   // Short counts keep the run brief
   localparam int unsigned HOLD = 8;
   localparam int unsigned SOFT = 8;
   localparam int unsigned HARD = 40;
   localparam int unsigned ACK  = 100;

   logic clk, rst_n, sel, pol, fw_req, fw_rel, fw_rd, uv_ev;
   logic disc, uvsw, netsw, facsw, shut, en;
   logic cut_en, rel_req, shut_req, power_hold, disc_st, uvlo_st;
   logic net_st, fact_st, shut_st, en_st, ind, fact_sel;
   logic net_go, fact_go, reboot;
   int   err_total, checks_done;
   int   n_req, n_shut, n_off, n_net, n_fac, n_boot;

   bmdi_ctrl #(.DISC_HOLD_CYCLES(HOLD), .SHUT_SOFT_CYCLES(SOFT),
      .SHUT_HARD_CYCLES(HARD), .RESTORE_ACK_CYCLES(ACK)) i_bmdi_ctrl
   (
      .clk                        (clk),
      .rst_n                      (rst_n),
      .disconnect_in              (disc),
      .uvlo_switch_in             (uvsw),
      .net_reset_switch_in        (netsw),
      .factory_restore_switch_in  (facsw),
      .shutdown_in                (shut),
      .enable_in                  (en),
      .disconnect_handling_select (sel),
      .disconnect_polarity        (pol),
      .fw_contactor_request       (fw_req),
      .fw_stack_release_done      (fw_rel),
      .fw_restore_done            (fw_rd),
      .uvlo_event                 (uv_ev),
      .contactor_drive_en         (cut_en),
      .stack_release_request      (rel_req),
      .shutdown_release_request   (shut_req),
      .power_hold                 (power_hold),
      .disconnect_state           (disc_st),
      .uvlo_enable_state          (uvlo_st),
      .net_reset_state            (net_st),
      .factory_restore_state      (fact_st),
      .shutdown_state             (shut_st),
      .enable_state               (en_st),
      .restore_indicate           (ind),
      .restore_factory_sel        (fact_sel),
      .net_reset_start            (net_go),
      .factory_restore_start      (fact_go),
      .reboot_request             (reboot)
   );

   bmdi_ext_ctrl #(.HOLD(HOLD)) i_bmdi_ext_ctrl
   (
      .clk                       (clk),
      .polarity                  (pol),
      .disconnect_in             (disc),
      .uvlo_switch_in            (uvsw),
      .net_reset_switch_in       (netsw),
      .factory_restore_switch_in (facsw),
      .shutdown_in               (shut),
      .enable_in                 (en)
   );

   always #50 clk = ~clk;

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic ok(input logic c, input string what);
      checks_done++;
      if (c !== 1'b1)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   function automatic int hi(input logic b);
      return (b === 1'b1) ? 1 : 0;
   endfunction

   // Pulses last one cycle, so every cycle is sampled
   task automatic watch(input int n);
      n_req = 0;
      n_shut = 0;
      n_off = 0;
      n_net = 0;
      n_fac = 0;
      n_boot = 0;
      repeat (n)
      begin
         step(1);
         fw_rel = 1'b0;
         fw_rd = 1'b0;
         n_req += hi(rel_req);
         n_shut += hi(shut_req);
         n_off += hi(~power_hold);
         n_net += hi(net_go);
         n_fac += hi(fact_go);
         n_boot += hi(reboot);
      end
   endtask

   task automatic boot(input logic net, input logic fact);
      rst_n = 1'b0;
      i_bmdi_ext_ctrl.boot_sel(net, fact);
      step(16);
      ok(power_hold === 1'b1 && (ind | cut_en | net_go) === 1'b0, "reset");
      rst_n = 1'b1;
      watch(8);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #(3000 * 100);
      err_total++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      conclude();
   end

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      sel = MODE_SOFT;
      pol = 1'b0;
      fw_req = 1'b1;
      fw_rel = 1'b0;
      fw_rd = 1'b0;
      uv_ev = 1'b0;
      err_total = 0;
      checks_done = 0;
      boot(1'b0, 1'b1);
      ok(ind === 1'b1 && fact_sel === 1'b1, "factory pattern");
      ok(fact_st === 1'b1 && net_st === 1'b0, "switch status");
      i_bmdi_ext_ctrl.ack_restore();
      watch(6);
      ok(n_fac == 1 && n_net == 0 && ind === 1'b1, "factory start");
      fw_rd = 1'b1;
      watch(4);
      ok(n_boot == 1 && ind === 1'b0, "factory reboot");
      $display("Test factory restore done");
      boot(1'b0, 1'b0);
      ok(ind === 1'b0, "pattern without request");
      for (int m = 0; m < 4; m++)
      begin
         sel = m[1];
         pol = m[0];
         step(6);
         i_bmdi_ext_ctrl.set_disc(1'b1, 1'b0);
         watch(4);
         ok(cut_en === ~sel, "contactor drive");
         ok(disc_st === pol, "pin level status");
         watch(HOLD + 2);
         ok(n_req == (sel ? 0 : 1) && cut_en === ~sel, "mode");
         i_bmdi_ext_ctrl.set_disc(1'b0, 1'b0);
         watch(6);
         ok(cut_en === 1'b1, "drive restored");
         i_bmdi_ext_ctrl.set_disc(1'b1, 1'b0);
         step(3);
         i_bmdi_ext_ctrl.set_disc(1'b0, 1'b1);
         watch(HOLD + 6);
         ok(n_req == 0, "glitch taken as request");
      end
      fw_req = 1'b0;
      watch(2);
      ok(cut_en === 1'b0, "drive without firmware request");
      fw_req = 1'b1;
      $display("Test disconnect done");
      i_bmdi_ext_ctrl.drive(1'b1, 1'b0, 1'b1);
      step(1);
      ok(shut_st === 1'b0, "status ahead of sync");
      watch(4);
      ok(shut_st === 1'b1 && uvlo_st === 1'b1, "status");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b0, 1'b1);
      watch(SOFT + 6);
      ok(n_shut + n_off == 0, "short shutdown acted");
      i_bmdi_ext_ctrl.drive(1'b1, 1'b0, 1'b1);
      watch(SOFT + 6);
      ok(n_shut == 1 && n_off == 0, "soft threshold");
      fw_rel = 1'b1;
      watch(3);
      ok(power_hold === 1'b0 && shut_st === 1'b0, "soft off");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b1, 1'b1);
      watch(5);
      ok(power_hold === 1'b1 && en_st === 1'b1, "enable wake");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b0, 1'b1);
      step(4);
      i_bmdi_ext_ctrl.drive(1'b1, 1'b0, 1'b1);
      watch(HARD - 10);
      ok(n_shut == 1 && n_off == 0, "early hard off");
      watch(15);
      ok(power_hold === 1'b0, "hard threshold");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b1, 1'b1);
      watch(5);
      ok(power_hold === 1'b1, "enable wake");
      i_bmdi_ext_ctrl.drive(1'b1, 1'b0, 1'b0);
      watch(HARD + 10);
      ok(n_off == 0, "off with lockout switch off");
      i_bmdi_ext_ctrl.drive(1'b1, 1'b1, 1'b1);
      watch(HARD + 10);
      ok(n_off == 0, "off despite enable");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b1, 1'b1);
      uv_ev = 1'b1;
      watch(5);
      ok(n_off == 0, "lockout overrode enable");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b0, 1'b0);
      watch(5);
      ok(n_off == 0 && uvlo_st === 1'b0, "lockout while off");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b0, 1'b1);
      watch(5);
      ok(power_hold === 1'b0, "lockout ignored");
      uv_ev = 1'b0;
      i_bmdi_ext_ctrl.drive(1'b0, 1'b1, 1'b1);
      watch(5);
      ok(power_hold === 1'b1, "enable wake");
      i_bmdi_ext_ctrl.drive(1'b0, 1'b0, 1'b1);
      $display("Test shutdown and enable done");
      boot(1'b1, 1'b0);
      ok(ind === 1'b1 && fact_sel === 1'b0, "network pattern");
      ok(net_st === 1'b1 && fact_st === 1'b0, "switch status");
      i_bmdi_ext_ctrl.ack_restore();
      watch(6);
      ok(n_net == 1 && n_fac == 0, "network start");
      fw_rd = 1'b1;
      watch(6);
      ok(n_boot == 0 && ind === 1'b0, "network reboot");
      $display("Test network reset done");
      boot(1'b1, 1'b1);
      watch(ACK - 12);
      ok(ind === 1'b1 && fact_sel === 1'b1, "early abandon");
      watch(30);
      ok(ind === 1'b0 && n_fac + n_net == 0, "no timeout");
      i_bmdi_ext_ctrl.ack_restore();
      watch(6);
      ok(n_fac + n_net == 0, "late acknowledge taken");
      $display("Test restore timeout done");
      conclude();
   end
endmodule
